// ===== pors_pkg.sv
// constants, register map and field layout for the power-on reset sequencer
// assumes one clock that is the input clock and also the reference clock
// Summary of operation
// - after the input is released the internal power-on reset stays asserted 1024 more periods.
// - after internal release the system pll lock is reached after 6400 divided-reference periods.
// - the hard reset output is released 512 reference periods after the pll reports lock.
// - the soft reset output is released 515 reference periods after lock, three after hard reset.
// - all straps are captured at the release edge of power-on reset and must be stable around it.
// - whenever hard reset is asserted the soft reset is asserted as well.
// - as configuration slave with no configuration word written, a default word is applied.
// - fourteen strap levels are sampled when power-on reset ends and set mode, boot and clocks.
package pors_pkg;
  localparam int unsigned STRETCH_CYC = 1024;
  localparam int unsigned PLL_LOCK_REF_CYC = 6400;
  localparam int unsigned HARD_REL_CYC = 512;
  localparam int unsigned SOFT_REL_CYC = 515;
  localparam int unsigned CNT_W = 16;
  localparam int unsigned STRAP_W = 14;

  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_STRAPS = 8'h08;
  localparam logic [7:0] OFS_CFG_WORD = 8'h0C;
  localparam logic [7:0] OFS_CFG_ACTIVE = 8'h10;

  localparam int unsigned CTRL_RDF_BIT = 0;
  localparam logic CTRL_RST = 1'b0;

  localparam int unsigned STRAP_RSTCFG_SEL = 0;
  localparam int unsigned STRAP_CFG_SRC_SEL = 1;
  localparam int unsigned STRAP_SLV_SYNC = 2;
  localparam int unsigned STRAP_SLV_WIDE = 3;
  localparam int unsigned STRAP_DIE_LO = 4;
  localparam int unsigned STRAP_BOOT_LO = 8;
  localparam int unsigned STRAP_WDOG = 11;
  localparam int unsigned STRAP_CLKMODE_LO = 12;

  localparam logic [31:0] CFG_WORD_RST = 32'h0000_0000;
  localparam logic [31:0] CFG_DEFAULT = 32'h0000_0000;

  typedef enum logic [2:0] {
    ST_HELD,
    ST_STRETCH,
    ST_PLL_WAIT,
    ST_RELEASE,
    ST_RUN
  } pors_state_e;
endpackage

// ===== pors_top.sv
// power-on reset sequencer with apb register access
// assumes the power-on reset and strap pins are asynchronous to CLK
//
// Decided for this implementation: the APB register port and the address map.
`timescale 1ns/100ps
module pors_top #(
  parameter int unsigned LOCK_REF_CYC = pors_pkg::PLL_LOCK_REF_CYC,
  parameter logic [31:0] DEFAULT_CFG = pors_pkg::CFG_DEFAULT
) (
  input wire logic CLK,
  input wire logic ARST_N,
  input wire logic POWER_ON_RESET_N,
  input wire logic [pors_pkg::STRAP_W-1:0] STRAPS,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  output logic INT_POWER_ON_RESET_N,
  output logic SYSTEM_PLL_LOCK,
  output logic HARD_RESET_O,
  output logic HARD_RESET_OE,
  output logic SOFT_RESET_O,
  output logic SOFT_RESET_OE,
  output logic [pors_pkg::STRAP_W-1:0] STRAP_LATCHED,
  output logic [31:0] CONFIG_WORD
);
  logic [1:0] rst_sync_r;
  logic rst_n;
  logic [2:0] por_sync_r;
  logic por_filt_r;
  logic [pors_pkg::STRAP_W-1:0] strap_s1_r;
  logic [pors_pkg::STRAP_W-1:0] strap_s2_r;
  logic [pors_pkg::STRAP_W-1:0] strap_s3_r;
  logic por_release;
  logic por_assert;
  pors_pkg::pors_state_e state_r;
  logic [pors_pkg::CNT_W-1:0] cnt_r;
  logic [pors_pkg::CNT_W-1:0] lock_cyc;
  logic rdf_two_r;
  logic [31:0] cfg_word_r;
  logic cfg_written_r;
  logic apb_acc;
  logic addr_ok;
  logic [31:0] rd_nxt;

  // reset release through two flops
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rst_sync_r <= 2'h0;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_r[1];

  // pin synchronisers, change counts once stages two and three agree
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      por_sync_r <= 3'h0;
      por_filt_r <= 1'b0;
      strap_s1_r <= '0;
      strap_s2_r <= '0;
      strap_s3_r <= '0;
    end else begin
      por_sync_r <= {por_sync_r[1:0], POWER_ON_RESET_N};
      strap_s1_r <= STRAPS;
      strap_s2_r <= strap_s1_r;
      strap_s3_r <= strap_s2_r;
      if (por_sync_r[1] == por_sync_r[2]) begin
        por_filt_r <= por_sync_r[2];
      end
    end
  end
  assign por_release = !por_filt_r && por_sync_r[1] && por_sync_r[2];
  assign por_assert = !por_filt_r || (!por_sync_r[1] && !por_sync_r[2]);

  // lock wait scaled by the reference division factor
  assign lock_cyc = rdf_two_r ? pors_pkg::CNT_W'(2 * LOCK_REF_CYC)
                              : pors_pkg::CNT_W'(LOCK_REF_CYC);

  // sequencing state
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= pors_pkg::ST_HELD;
    end else if (por_assert) begin
      if (por_release) begin
        state_r <= pors_pkg::ST_STRETCH;
      end else begin
        state_r <= pors_pkg::ST_HELD;
      end
    end else begin
      case (state_r)
        pors_pkg::ST_HELD: begin
          state_r <= pors_pkg::ST_STRETCH;
        end
        pors_pkg::ST_STRETCH: begin
          if (cnt_r == pors_pkg::CNT_W'(pors_pkg::STRETCH_CYC - 1)) begin
            state_r <= pors_pkg::ST_PLL_WAIT;
          end
        end
        pors_pkg::ST_PLL_WAIT: begin
          if (cnt_r == lock_cyc - 1'b1) begin
            state_r <= pors_pkg::ST_RELEASE;
          end
        end
        pors_pkg::ST_RELEASE: begin
          if (cnt_r == pors_pkg::CNT_W'(pors_pkg::SOFT_REL_CYC - 1)) begin
            state_r <= pors_pkg::ST_RUN;
          end
        end
        pors_pkg::ST_RUN: begin
          state_r <= pors_pkg::ST_RUN;
        end
        default: begin
          state_r <= pors_pkg::ST_HELD;
        end
      endcase
    end
  end

  // phase counter, cleared at each phase boundary except the step into ST_RUN, where it holds its last value
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= '0;
    end else if (por_assert) begin
      cnt_r <= '0;
    end else begin
      case (state_r)
        pors_pkg::ST_HELD: begin
          cnt_r <= '0;
        end
        pors_pkg::ST_STRETCH: begin
          if (cnt_r == pors_pkg::CNT_W'(pors_pkg::STRETCH_CYC - 1)) begin
            cnt_r <= '0;
          end else begin
            cnt_r <= cnt_r + 1'b1;
          end
        end
        pors_pkg::ST_PLL_WAIT: begin
          if (cnt_r == lock_cyc - 1'b1) begin
            cnt_r <= '0;
          end else begin
            cnt_r <= cnt_r + 1'b1;
          end
        end
        pors_pkg::ST_RELEASE: begin
          if (cnt_r != pors_pkg::CNT_W'(pors_pkg::SOFT_REL_CYC - 1)) begin
            cnt_r <= cnt_r + 1'b1;
          end
        end
        pors_pkg::ST_RUN: begin
          cnt_r <= cnt_r;
        end
        default: begin
          cnt_r <= '0;
        end
      endcase
    end
  end

  // open-drain pin values, always low
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      HARD_RESET_O <= 1'b0;
      SOFT_RESET_O <= 1'b0;
    end else begin
      HARD_RESET_O <= 1'b0;
      SOFT_RESET_O <= 1'b0;
    end
  end

  // internal power-on reset
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      INT_POWER_ON_RESET_N <= 1'b0;
    end else if (por_assert || state_r == pors_pkg::ST_HELD) begin
      INT_POWER_ON_RESET_N <= 1'b0;
    end else if (state_r == pors_pkg::ST_STRETCH &&
                 cnt_r == pors_pkg::CNT_W'(pors_pkg::STRETCH_CYC - 1)) begin
      INT_POWER_ON_RESET_N <= 1'b1;
    end
  end

  // modelled pll lock
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      SYSTEM_PLL_LOCK <= 1'b0;
    end else if (por_assert || state_r == pors_pkg::ST_HELD) begin
      SYSTEM_PLL_LOCK <= 1'b0;
    end else if (state_r == pors_pkg::ST_PLL_WAIT && cnt_r == lock_cyc - 1'b1) begin
      SYSTEM_PLL_LOCK <= 1'b1;
    end
  end

  // hard reset drive
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      HARD_RESET_OE <= 1'b1;
    end else if (por_assert || state_r == pors_pkg::ST_HELD) begin
      HARD_RESET_OE <= 1'b1;
    end else if (state_r == pors_pkg::ST_RELEASE &&
                 cnt_r == pors_pkg::CNT_W'(pors_pkg::HARD_REL_CYC - 1)) begin
      HARD_RESET_OE <= 1'b0;
    end
  end

  // soft reset drive, never free while hard reset is driven
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      SOFT_RESET_OE <= 1'b1;
    end else if (por_assert || state_r == pors_pkg::ST_HELD) begin
      SOFT_RESET_OE <= 1'b1;
    end else if (state_r == pors_pkg::ST_RELEASE && !HARD_RESET_OE &&
                 cnt_r == pors_pkg::CNT_W'(pors_pkg::SOFT_REL_CYC - 1)) begin
      SOFT_RESET_OE <= 1'b0;
    end
  end

  // strap capture on the release edge of power-on reset
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      STRAP_LATCHED <= '0;
    end else if (por_release) begin
      STRAP_LATCHED <= strap_s3_r;
    end
  end

  // applied configuration word
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      CONFIG_WORD <= pors_pkg::CFG_WORD_RST;
    end else if (!STRAP_LATCHED[pors_pkg::STRAP_CFG_SRC_SEL] && !cfg_written_r) begin
      CONFIG_WORD <= DEFAULT_CFG;
    end else begin
      CONFIG_WORD <= cfg_word_r;
    end
  end

  // apb slave, one wait state per transfer
  assign apb_acc = PSEL && PENABLE && !PREADY;
  assign addr_ok = PADDR == pors_pkg::OFS_CTRL || PADDR == pors_pkg::OFS_STATUS ||
                   PADDR == pors_pkg::OFS_STRAPS || PADDR == pors_pkg::OFS_CFG_WORD ||
                   PADDR == pors_pkg::OFS_CFG_ACTIVE;

  always_comb begin
    rd_nxt = 32'h0000_0000;
    case (PADDR)
      pors_pkg::OFS_CTRL: rd_nxt[pors_pkg::CTRL_RDF_BIT] = rdf_two_r;
      pors_pkg::OFS_STATUS: rd_nxt = {23'h000000, cfg_written_r, SOFT_RESET_OE, HARD_RESET_OE,
                                      SYSTEM_PLL_LOCK, INT_POWER_ON_RESET_N, 1'b0, state_r};
      pors_pkg::OFS_STRAPS: rd_nxt = {18'h00000, STRAP_LATCHED};
      pors_pkg::OFS_CFG_WORD: rd_nxt = cfg_word_r;
      pors_pkg::OFS_CFG_ACTIVE: rd_nxt = CONFIG_WORD;
      default: rd_nxt = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      PREADY <= 1'b0;
    end else begin
      PREADY <= apb_acc;
    end
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      PSLVERR <= 1'b0;
    end else begin
      PSLVERR <= apb_acc && !addr_ok;
    end
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      PRDATA <= 32'h0000_0000;
    end else begin
      PRDATA <= (apb_acc && !PWRITE) ? rd_nxt : 32'h0000_0000;
    end
  end

  // software writes take effect at the completing edge
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      rdf_two_r <= pors_pkg::CTRL_RST;
    end else if (PSEL && PENABLE && PREADY && PWRITE && PADDR == pors_pkg::OFS_CTRL) begin
      rdf_two_r <= PWDATA[pors_pkg::CTRL_RDF_BIT];
    end
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      cfg_word_r <= pors_pkg::CFG_WORD_RST;
    end else if (PSEL && PENABLE && PREADY && PWRITE && PADDR == pors_pkg::OFS_CFG_WORD) begin
      cfg_word_r <= PWDATA;
    end
  end

  // write wins over the clear by power-on reset
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      cfg_written_r <= 1'b0;
    end else if (PSEL && PENABLE && PREADY && PWRITE && PADDR == pors_pkg::OFS_CFG_WORD) begin
      cfg_written_r <= 1'b1;
    end else if (por_assert) begin
      cfg_written_r <= 1'b0;
    end
  end
endmodule

// ===== pors_board.sv
// board reset supervisor and strap drivers
// assumes go is a one-cycle pulse in the clk domain
`timescale 1ns/100ps
module pors_board #(
  parameter int HOLD = 16
) (
  input wire logic clk,
  input wire logic go,
  input wire logic [13:0] strap_val,
  output logic por_n,
  output logic [13:0] straps
);
  int cnt = 0;
  initial por_n = 1'b0;
  initial straps = '0;
  always @(posedge clk) begin
    if (go) begin
      cnt <= 0;
      por_n <= 1'b0;
      straps <= strap_val;
    end else if (cnt < HOLD) begin
      cnt <= cnt + 1;
    end else if (!por_n) begin
      por_n <= 1'b1;
    end else begin
      straps <= ~strap_val;
    end
  end
endmodule

// ===== pors_top_monitor.sv
// checker on the sequencer ports
// assumes binding to pors_top, one clock domain
`timescale 1ns/100ps
module pors_top_monitor #(
  parameter int unsigned LOCK_REF_CYC = 8
) (
  input wire logic CLK,
  input wire logic ARST_N,
  input wire logic POWER_ON_RESET_N,
  input wire logic INT_POWER_ON_RESET_N,
  input wire logic SYSTEM_PLL_LOCK,
  input wire logic HARD_RESET_OE,
  input wire logic SOFT_RESET_OE,
  input wire logic [pors_pkg::STRAP_W-1:0] STRAP_LATCHED
);
  int unsigned hi_r;
  int unsigned lk_r;
  default clocking @(posedge CLK); endclocking
  default disable iff (!ARST_N);
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      hi_r <= 0;
      lk_r <= 0;
    end else begin
      hi_r <= POWER_ON_RESET_N ? hi_r + 1 : 0;
      lk_r <= (INT_POWER_ON_RESET_N && !SYSTEM_PLL_LOCK) ? lk_r + 1 : 0;
    end
  end
  sequence s_soft_tail;
    SOFT_RESET_OE [*3] ##1 !SOFT_RESET_OE;
  endsequence
  sequence s_hard_tail;
    ##[511:511] HARD_RESET_OE ##1 !HARD_RESET_OE;
  endsequence
  a_soft_with_hard: assert property (HARD_RESET_OE |-> SOFT_RESET_OE)
    else $error("soft reset free while hard reset held");
  a_soft_gap: assert property ($fell(HARD_RESET_OE) |-> s_soft_tail)
    else $error("soft reset release not three cycles after hard");
  a_hard_gap: assert property ($rose(SYSTEM_PLL_LOCK) |-> s_hard_tail)
    else $error("hard reset release not 512 cycles after lock");
  a_lock_wait: assert property ($rose(SYSTEM_PLL_LOCK) |->
    (lk_r - LOCK_REF_CYC <= 1) || (lk_r - 2 * LOCK_REF_CYC <= 1))
    else $error("pll lock wait length wrong");
  a_stretch_len: assert property ($rose(INT_POWER_ON_RESET_N) |->
    hi_r inside {[1025:1034]}) else $error("internal reset stretch wrong");
  a_por_assert: assert property ($fell(POWER_ON_RESET_N) |-> ##[1:5]
    (!INT_POWER_ON_RESET_N && HARD_RESET_OE)) else $error("reset not reasserted");
  a_held_state: assert property (!INT_POWER_ON_RESET_N |->
    !SYSTEM_PLL_LOCK && HARD_RESET_OE) else $error("lock or release during reset");
  a_strap_hold: assert property (INT_POWER_ON_RESET_N && $past(INT_POWER_ON_RESET_N)
    |-> $stable(STRAP_LATCHED)) else $error("latched straps changed");
endmodule
bind pors_top pors_top_monitor #(.LOCK_REF_CYC(LOCK_REF_CYC)) i_pors_top_monitor (
  .CLK(CLK), .ARST_N(ARST_N), .POWER_ON_RESET_N(POWER_ON_RESET_N),
  .INT_POWER_ON_RESET_N(INT_POWER_ON_RESET_N), .SYSTEM_PLL_LOCK(SYSTEM_PLL_LOCK),
  .HARD_RESET_OE(HARD_RESET_OE), .SOFT_RESET_OE(SOFT_RESET_OE),
  .STRAP_LATCHED(STRAP_LATCHED));

// ===== test_power_on_reset_sequencer.sv
// self-checking bench for the power-on reset sequencer
// assumes pors_board as the board side, apb master in here
`timescale 1ns/100ps
module test_power_on_reset_sequencer;
  localparam logic [31:0] DEF = 32'hC3C3_5A5A;
  logic clk, arst_n = 0, psel = 0, pen = 0, pwr = 0, go = 0, er;
  logic pready, pslverr, int_por_n, lock, hard_oe, soft_oe, por_n, hard_o, soft_o;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, cfg_word, rd;
  logic [13:0] straps, strap_lat, strap_val = 0;
  int fails = 0, checked = 0, cyc = 0;
  pors_board i_pors_board (.clk(clk), .go(go), .strap_val(strap_val), .por_n(por_n),
    .straps(straps));
  pors_top #(.LOCK_REF_CYC(8), .DEFAULT_CFG(DEF)) i_pors_top (
    .CLK(clk), .ARST_N(arst_n), .POWER_ON_RESET_N(por_n), .STRAPS(straps), .PSEL(psel),
    .PENABLE(pen), .PWRITE(pwr), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .INT_POWER_ON_RESET_N(int_por_n),
    .SYSTEM_PLL_LOCK(lock), .HARD_RESET_O(hard_o), .HARD_RESET_OE(hard_oe), .SOFT_RESET_O(soft_o),
    .SOFT_RESET_OE(soft_oe), .STRAP_LATCHED(strap_lat), .CONFIG_WORD(cfg_word));
  initial begin
    clk = 0;
    forever #10 clk = ~clk;
  end
  task automatic end_sim;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      end_sim();
    end
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask
  task automatic pulse_go(input logic [13:0] sv);
    strap_val <= sv;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    @(posedge clk);
  endtask
  task automatic seq(input int r, input logic [13:0] sv, input logic re);
    int n;
    apb(1'b1, pors_pkg::OFS_CTRL, 32'(r - 1));
    pulse_go(sv);
    if (re) begin
      repeat (300) @(posedge clk);
      chk("int_por_early", 0, int_por_n);
      pulse_go(sv);
    end
    while (por_n !== 1'b1) @(posedge clk);
    n = 0;
    while (int_por_n !== 1'b1) begin @(posedge clk); n++; end
    chk("stretch", 1, n >= 1024 && n <= 1034);
    n = 0;
    while (lock !== 1'b1) begin @(posedge clk); n++; end
    chk("lock_wait", 1, n >= 8 * r && n <= 8 * r + 1);
    n = 0;
    while (hard_oe !== 1'b0) begin @(posedge clk); n++; end
    chk("hard_gap", 512, n);
    n = 0;
    while (soft_oe !== 1'b0) begin @(posedge clk); n++; end
    chk("soft_gap", 3, n);
    chk("hard_o", 0, hard_o);
    chk("soft_o", 0, soft_o);
    chk("strap_lat", sv, strap_lat);
    apb(1'b0, pors_pkg::OFS_STRAPS, 0);
    chk("strap_reg", sv, rd);
    chk("strap_err", 0, er);
    if (!sv[1]) begin
      chk("cfg_default", DEF, cfg_word);
      apb(1'b1, pors_pkg::OFS_CFG_WORD, 32'h1234_5678);
      apb(1'b0, pors_pkg::OFS_CFG_ACTIVE, 0);
      chk("cfg_written", 32'h1234_5678, cfg_word);
    end
  endtask
  initial begin
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk);
    seq(1, 14'h2A5C, 1'b0);
    apb(1'b0, pors_pkg::OFS_STATUS, 0);
    chk("status", 32'h0000_0134, rd);
    apb(1'b0, 8'h20, 0);
    chk("unmapped_err", 1, er);
    chk("unmapped_data", 0, rd);
    seq(2, 14'h15A3, 1'b1);
    pulse_go(14'h0F0F);
    repeat (8) @(posedge clk);
    chk("reassert_int", 0, int_por_n);
    chk("reassert_soft", 1, soft_oe);
    end_sim();
  end
endmodule
